// *** rtl/vdram_host.sv ***
// Implementation choices: the register offsets and the APB interface to the registers.
module vdram_host
  import vdram_host_pkg::*;
#(
  parameter int BLOCK_COLS = vdram_host_pkg::BLOCK_COLS_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory pins
  output vdram_host_pkg::dram_pins_s pins,
  input wire logic [15:0] dq_in
);
  import vdram_host_pkg::*;

  typedef enum {st_idle, st_row, st_ras, st_col, st_cas, st_end, st_pre} state_e;

  // ignored low column bits: 2 for 4-column, 3 for 8-column blocks
  localparam logic [8:0] BLOCK_KEEP = (BLOCK_COLS == 4) ? 9'h1fc : 9'h1f8;

  logic [8:0] row_addr;
  logic [8:0] col_addr;
  logic [15:0] data_word;
  logic [15:0] wmask;
  cmd_e cmd;
  logic lower_en;
  logic upper_en;
  logic persist;
  logic refused;
  logic [1:0] color_valid;
  logic [15:0] dq_seen;
  state_e state;
  logic [3:0] cnt;

  logic [8:0] next_row_addr;
  logic [8:0] next_col_addr;
  logic [15:0] next_data_word;
  logic [15:0] next_wmask;
  cmd_e next_cmd;
  logic next_lower_en;
  logic next_upper_en;
  logic next_persist;
  logic next_refused;
  logic [1:0] next_color_valid;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  state_e next_state;
  logic [3:0] next_cnt;
  dram_pins_s next_pins;

  logic apb_done;
  logic wr_go;
  logic start;
  logic [1:0] want_bytes;
  logic is_xfer;

  pin_sync3 #(
    .W(16)
  ) u_dq_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(dq_in),
    .q(dq_seen)
  );

  // write lands at the edge where pready is seen high
  assign apb_done = psel & penable & pready;
  assign wr_go = apb_done & pwrite & (paddr == OFS_CTRL) & pwdata[CTRL_GO_BIT];
  assign want_bytes = {pwdata[CTRL_UPPER_BIT], pwdata[CTRL_LOWER_BIT]};
  assign is_xfer = (cmd == cmd_full_xfer) | (cmd == cmd_split_xfer);

  // a block write over a color byte never loaded is refused
  always_comb
  begin
    start = 1'b0;
    if (wr_go && state == st_idle)
    begin
      if (cmd_e'(pwdata[CTRL_CMD_LSB +: 2]) != cmd_block_write)
        start = 1'b1;
      else if ((want_bytes & ~color_valid) == 2'b00)
        start = 1'b1;
    end
  end

  // register file
  always_comb
  begin
    next_row_addr = row_addr;
    next_col_addr = col_addr;
    next_data_word = data_word;
    next_wmask = wmask;
    next_cmd = cmd;
    next_lower_en = lower_en;
    next_upper_en = upper_en;
    next_persist = persist;
    next_refused = refused;
    next_color_valid = color_valid;
    next_prdata = prdata;
    next_pready = psel & penable & ~pready;
    next_pslverr = 1'b0;
    if (psel && penable && !pready)
    begin
      unique case (paddr)
        OFS_CTRL: next_prdata = {23'h000000, 1'b0, 1'b0, persist, upper_en, lower_en,
                                 2'b00, 2'(cmd)};
        OFS_ROW: next_prdata = {23'h000000, row_addr};
        OFS_COL: next_prdata = {23'h000000, col_addr};
        OFS_DATA: next_prdata = {16'h0000, data_word};
        OFS_WMASK: next_prdata = {16'h0000, wmask};
        OFS_STATUS: next_prdata = {dq_seen, 12'h000, color_valid, refused,
                                   (state != st_idle)};
        default:
        begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (apb_done && pwrite)
    begin
      unique case (paddr)
        OFS_ROW: next_row_addr = pwdata[8:0];
        OFS_COL: next_col_addr = pwdata[8:0];
        OFS_DATA: next_data_word = pwdata[15:0];
        OFS_WMASK: next_wmask = pwdata[15:0];
        default:
        begin
        end
      endcase
    end
    if (wr_go && state == st_idle)
      next_refused = ~start;
    if (start)
    begin
      next_cmd = cmd_e'(pwdata[CTRL_CMD_LSB +: 2]);
      next_lower_en = pwdata[CTRL_LOWER_BIT];
      next_upper_en = pwdata[CTRL_UPPER_BIT];
      next_persist = pwdata[CTRL_PERSIST_BIT];
    end
    // color bytes stay valid once loaded; only reset clears them
    if (state == st_cas && cnt == 4'h0 && cmd == cmd_load_color)
      next_color_valid = color_valid | {upper_en, lower_en};
  end

  // strobe sequencer; pins change only on a state step
  always_comb
  begin
    next_state = state;
    next_cnt = 4'(cnt + 4'h1);
    next_pins = pins;
    unique case (state)
      st_idle:
      begin
        next_cnt = 4'h0;
        next_pins = PINS_IDLE;
        if (start)
          next_state = st_row;
      end
      st_row:
      begin
        // row address and row-fall qualifiers in place
        next_pins.addr = row_addr;
        next_pins.transfer_output_select_b = ~is_xfer;
        next_pins.special_function_select = (cmd == cmd_load_color)
                                           | (cmd == cmd_split_xfer);
        next_pins.we_b = ~((cmd == cmd_block_write) & ~persist);
        next_pins.dq_out = wmask;
        next_pins.dq_oe_b = next_pins.we_b ? 16'hffff : 16'h0000;
        if (cnt == STEP_CYC - 4'h1)
        begin
          next_state = st_ras;
          next_cnt = 4'h0;
        end
      end
      st_ras:
      begin
        next_pins.ras_b = 1'b0;
        if (cnt == STEP_CYC - 4'h1)
        begin
          next_state = st_col;
          next_cnt = 4'h0;
        end
      end
      st_col:
      begin
        // early write: write strobe low before the column fall
        next_pins.addr = (cmd == cmd_block_write) ? (col_addr & BLOCK_KEEP)
                       : col_addr;
        next_pins.special_function_select = ~is_xfer;
        next_pins.we_b = is_xfer;
        next_pins.dq_out = data_word;
        next_pins.dq_oe_b = is_xfer ? 16'hffff : 16'h0000;
        if (cnt == STEP_CYC - 4'h1)
        begin
          next_state = st_cas;
          next_cnt = 4'h0;
        end
      end
      st_cas:
      begin
        next_pins.lower_column_strobe_b = ~(lower_en | is_xfer);
        next_pins.upper_column_strobe_b = ~(upper_en | is_xfer);
        if (cnt == STEP_CYC - 4'h1)
        begin
          next_state = st_end;
          next_cnt = 4'h0;
        end
      end
      st_end:
      begin
        next_pins = PINS_IDLE;
        if (cnt == STEP_CYC - 4'h1)
        begin
          next_state = st_pre;
          next_cnt = 4'h0;
        end
      end
      st_pre:
      begin
        // row precharge before the next command may start
        if (cnt == PRE_CYC - 4'h1)
        begin
          next_state = st_idle;
          next_cnt = 4'h0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      row_addr <= ROW_RST;
      col_addr <= COL_RST;
      data_word <= DATA_RST;
      wmask <= WMASK_RST;
      cmd <= cmd_load_color;
      lower_en <= 1'b0;
      upper_en <= 1'b0;
      persist <= 1'b0;
      refused <= 1'b0;
      color_valid <= 2'b00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state <= st_idle;
      cnt <= 4'h0;
      pins <= PINS_IDLE;
    end
    else
    begin
      row_addr <= next_row_addr;
      col_addr <= next_col_addr;
      data_word <= next_data_word;
      wmask <= next_wmask;
      cmd <= next_cmd;
      lower_en <= next_lower_en;
      upper_en <= next_upper_en;
      persist <= next_persist;
      refused <= next_refused;
      color_valid <= next_color_valid;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
    end
  end
endmodule

// *** rtl/vdram_host_pkg.sv ***
package vdram_host_pkg;

  // register offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROW = 8'h04;
  localparam logic [7:0] OFS_COL = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_WMASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // control word fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_LOWER_BIT = 4;
  localparam int CTRL_UPPER_BIT = 5;
  localparam int CTRL_PERSIST_BIT = 6;
  localparam int CTRL_GO_BIT = 8;

  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_COLOR_LSB = 2;
  localparam int STAT_DQ_LSB = 16;

  // reset values
  localparam logic [8:0] ROW_RST = 9'h000;
  localparam logic [8:0] COL_RST = 9'h000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] WMASK_RST = 16'hffff;

  // block-write organisation: 4 or 8 columns per block
  localparam int BLOCK_COLS_DEFAULT = 8;

  // strobe timing
  localparam int CLK_NS = 40;
  localparam int T_STEP_NS = 40;
  localparam int T_PRECHARGE_NS = 60;
  localparam logic [3:0] STEP_CYC = 4'((T_STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PRE_CYC = 4'((T_PRECHARGE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    cmd_load_color,
    cmd_block_write,
    cmd_full_xfer,
    cmd_split_xfer
  } cmd_e;

  // memory-side pins; strobes active low, dq_oe_b low while driving
  typedef struct packed {
    logic ras_b;
    logic lower_column_strobe_b;
    logic upper_column_strobe_b;
    logic we_b;
    logic special_function_select;
    logic transfer_output_select_b;
    logic [8:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe_b;
  } dram_pins_s;

  localparam dram_pins_s PINS_IDLE = '{
    ras_b: 1'b1,
    lower_column_strobe_b: 1'b1,
    upper_column_strobe_b: 1'b1,
    we_b: 1'b1,
    special_function_select: 1'b0,
    transfer_output_select_b: 1'b1,
    addr: 9'h000,
    dq_out: 16'h0000,
    dq_oe_b: 16'hffff
  };

endpackage

// *** rtl/pin_sync3.sv ***
module pin_sync3 #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // pins in, filtered value out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // a bit moves only once stages two and three agree
  always_comb
  begin
    next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// *** tb/vdram_host_monitor.sv ***
module vdram_host_monitor #(
  parameter int BLOCK_COLS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory pins
  input wire vdram_host_pkg::dram_pins_s pins,
  input wire logic [15:0] dq_in
);
  import vdram_host_pkg::*;
  wire ras_b = pins.ras_b;
  wire lo_b = pins.lower_column_strobe_b;
  wire up_b = pins.upper_column_strobe_b;
  wire trg_b = pins.transfer_output_select_b;
  wire sfs = pins.special_function_select;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  AST_WAIT_STATE: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_UNMAPPED: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not flagged");
  AST_XFER_PINS: assert property ($fell(ras_b) && !trg_b |-> pins.we_b && lo_b && up_b)
    else $error("transfer strobes wrong at row fall");
  AST_XFER_COLS: assert property ($fell(ras_b) && !trg_b |-> ##2 !lo_b && !up_b)
    else $error("transfer column strobes missing");
  AST_CMD_SFS: assert property ($fell(ras_b) && trg_b |->
    ##2 ($fell(lo_b) || $fell(up_b)) && sfs && !pins.we_b && pins.dq_oe_b == 16'h0000)
    else $error("select, write strobe or data wrong at column fall");
  AST_MASK_DRIVE: assert property ($fell(ras_b) && !pins.we_b |->
    trg_b && !sfs && pins.dq_oe_b == 16'h0000)
    else $error("write mask not driven at row fall");
  AST_BLOCK_ADDR: assert property ($fell(ras_b) && trg_b && !sfs ##2 1'b1 |->
    (pins.addr & 9'(BLOCK_COLS - 1)) == 9'h000)
    else $error("ignored block address bits not clear");
endmodule

bind vdram_host vdram_host_monitor #(.BLOCK_COLS(BLOCK_COLS)) vdram_host_monitor_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .dq_in(dq_in));

// *** tb/vdram_dev_model.sv ***
module vdram_dev_model #(
  parameter int BLOCK_COLS = 8
) (
  // controller pins
  input wire vdram_host_pkg::dram_pins_s pins,
  // dq wire level
  output logic [15:0] dq_wire
);
  import vdram_host_pkg::*;
  logic [15:0] last_dq = 16'h0000;
  logic [15:0] color = 16'h0000;
  logic [15:0] wmask = 16'hffff;
  logic [15:0] mem [0:511];
  logic [8:0] xfer_row, xfer_col;
  logic in_xfer, is_load, xfer_split;
  int n_ras = 0;
  wire col_any = pins.lower_column_strobe_b & pins.upper_column_strobe_b;
  wire [15:0] lane_on = {{8{!pins.upper_column_strobe_b}}, {8{!pins.lower_column_strobe_b}}};
  wire [8:0] base = pins.addr & 9'(~(BLOCK_COLS - 1));
  // released bus shows the inverse, so stale data never looks valid
  always @(pins) last_dq = (pins.dq_out & ~pins.dq_oe_b) | (last_dq & pins.dq_oe_b);
  assign dq_wire = (pins.dq_out & ~pins.dq_oe_b) | (~last_dq & pins.dq_oe_b);
  initial foreach (mem[i]) mem[i] = 16'h0000;
  always @(negedge pins.ras_b)
  begin
    n_ras = n_ras + 1;
    in_xfer = !pins.transfer_output_select_b && pins.we_b && col_any;
    xfer_split = pins.special_function_select;
    is_load = pins.special_function_select && !in_xfer;
    xfer_row = pins.addr;
    // no mask-load cycle exists here, so write strobe high means unmasked
    wmask = pins.we_b ? 16'hffff : dq_wire;
  end
  always @(negedge col_any)
  begin
    if (in_xfer)
      xfer_col = pins.addr;
    else if (is_load)
      color = (color & ~lane_on) | (dq_wire & lane_on);
    else if (pins.special_function_select)
      for (int c = 0; c < BLOCK_COLS; c++)
        for (int l = 0; l < 16; l++)
          if (lane_on[l] && wmask[l] && dq_wire[(l / BLOCK_COLS) * BLOCK_COLS + c])
            mem[base + 9'(c)][l] = color[l];
  end
endmodule

// *** tb/tb.sv ***
`define CHK(n, e, g) \
  begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vdram_host_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err;
  dram_pins_s pins;
  logic [15:0] dq_in;
  int n_fail = 0;
  int n_tests = 0;
  logic [15:0] exp8 [0:7] = '{16'h00d5, 16'ha3d5, 16'ha3d5, 16'ha3d5,
                              16'ha300, 16'h0000, 16'ha300, 16'h0000};
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  vdram_host #(.BLOCK_COLS(8)) vdram_host_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
  vdram_dev_model #(.BLOCK_COLS(8)) vdram_dev_model_inst (.pins(pins), .dq_wire(dq_in));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge clk_sys);
    end
    if (k == 20) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] ctl(cmd_e c, logic [1:0] byt, logic pers);
    return 32'(c) | 32'(byt) << CTRL_LOWER_BIT | 32'(pers) << CTRL_PERSIST_BIT;
  endfunction
  // polls status until idle; a refused command never shows busy
  task automatic run(input logic [31:0] c);
    int k;
    k = 0;
    apb(1'b1, OFS_CTRL, c | (32'h1 << CTRL_GO_BIT));
    q = 32'h1;
    while (q[STAT_BUSY_BIT] !== 1'b0 && k < 40)
    begin
      k++;
      apb(1'b0, OFS_STATUS, 32'h0);
    end
    // a sequence that never ends is a mismatch
    if (k == 40) n_fail++;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, OFS_WMASK, 32'h0);
    `CHK("wmask_rst", 32'(WMASK_RST), q)
    apb(1'b0, OFS_ROW, 32'h0);
    `CHK("row_rst", 32'(ROW_RST), q)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("stat_rst", 16'h0000, q[15:0])
    `CHK("dq_idle", 16'hffff, q[31:16])
    $display("test reset done");
    apb(1'b1, OFS_DATA, 32'he3dd);
    run(ctl(cmd_block_write, 2'b11, 1'b0));
    `CHK("refused", 1'b1, q[STAT_REFUSED_BIT])
    `CHK("no_ras", 0, vdram_dev_model_inst.n_ras)
    run(ctl(cmd_load_color, 2'b01, 1'b0));
    `CHK("color_lo", 16'h00dd, vdram_dev_model_inst.color)
    `CHK("valid_lo", 2'b01, q[STAT_COLOR_LSB+:2])
    run(ctl(cmd_block_write, 2'b10, 1'b0));
    `CHK("refused_up", 1'b1, q[STAT_REFUSED_BIT])
    run(ctl(cmd_load_color, 2'b10, 1'b0));
    `CHK("color", 16'he3dd, vdram_dev_model_inst.color)
    $display("test color done");
    apb(1'b1, OFS_ROW, 32'h5);
    apb(1'b1, OFS_COL, 32'h003);
    apb(1'b1, OFS_DATA, 32'h5e0f);
    apb(1'b1, OFS_WMASK, 32'hbff7);
    run(ctl(cmd_block_write, 2'b11, 1'b0));
    `CHK("refused_clr", 1'b0, q[STAT_REFUSED_BIT])
    for (int i = 0; i < 8; i++)
      `CHK("blk8", exp8[i], vdram_dev_model_inst.mem[i])
    $display("test block8 done");
    apb(1'b1, OFS_COL, 32'h00f);
    apb(1'b1, OFS_DATA, 32'h0101);
    apb(1'b1, OFS_WMASK, 32'h0f0f);
    run(ctl(cmd_block_write, 2'b01, 1'b1));
    `CHK("blk_pers", 16'h00dd, vdram_dev_model_inst.mem[8])
    `CHK("blk_col1", 16'h0000, vdram_dev_model_inst.mem[9])
    $display("test persist done");
    apb(1'b1, OFS_ROW, 32'h1a5);
    apb(1'b1, OFS_COL, 32'h17e);
    run(ctl(cmd_full_xfer, 2'b11, 1'b0));
    `CHK("xrow", 9'h1a5, vdram_dev_model_inst.xfer_row)
    `CHK("xcol", 9'h17e, vdram_dev_model_inst.xfer_col)
    `CHK("xfull", 1'b0, vdram_dev_model_inst.xfer_split)
    run(ctl(cmd_split_xfer, 2'b11, 1'b0));
    `CHK("xsplit", 1'b1, vdram_dev_model_inst.xfer_split)
    `CHK("mem_kept", 16'h00d5, vdram_dev_model_inst.mem[0])
    `CHK("color_kept", 16'he3dd, vdram_dev_model_inst.color)
    $display("test transfer done");
    complete_run();
  end
endmodule
